// [nvmcf_nvm_cfg.sv]
// Size, type and configuration fields of the non-volatile memory control register.
// Assumes an AXI4-Lite master on core_clk_i and a memory loader on the same clock.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "nvmcf_map.svh"

module nvmcf_nvm_cfg
  import nvmcf_pkg::*;
(
  input wire logic core_clk_i,                // Core clock, 200 MHz.
  input wire logic sys_rst_i,                 // Synchronous reset, active high.
  input wire logic [31:0] s_axi_awaddr,       // Write address.
  input wire logic s_axi_awvalid,             // Write address valid.
  output logic s_axi_awready,                 // Write address ready.
  input wire logic [31:0] s_axi_wdata,        // Write data.
  input wire logic [3:0] s_axi_wstrb,         // Write byte strobes.
  input wire logic s_axi_wvalid,              // Write data valid.
  output logic s_axi_wready,                  // Write data ready.
  output logic [1:0] s_axi_bresp,             // Write response.
  output logic s_axi_bvalid,                  // Write response valid.
  input wire logic s_axi_bready,              // Write response ready.
  input wire logic [31:0] s_axi_araddr,       // Read address.
  input wire logic s_axi_arvalid,             // Read address valid.
  output logic s_axi_arready,                 // Read address ready.
  output logic [31:0] s_axi_rdata,            // Read data.
  output logic [1:0] s_axi_rresp,             // Read response.
  output logic s_axi_rvalid,                  // Read data valid.
  input wire logic s_axi_rready,              // Read data ready.
  input wire logic nvm_kind_strap_pin_i,      // Memory type strap, 1 means flash.
  input wire logic nvm_load_valid_i,          // Auto-read word valid pulse.
  input wire logic [7:0] nvm_load_addr_i,     // Auto-read word address.
  input wire logic [15:0] nvm_load_data_i,    // Auto-read word data.
  input wire logic flash_write_cycle_i,       // Flash write cycle pulse.
  output logic eeprom_addr_width_sel_o,       // EEPROM 16-bit addressing.
  output logic [3:0] eeprom_capacity_code_o,  // Capacity code.
  output logic [1:0] nvm_addr_byte_count_o,   // Address-byte count.
  output logic [1:0] nvm_kind_o,              // Informational memory kind.
  output logic nvm_is_flash_o,                // Operational type from strap.
  output logic nvm_sig_valid_o,               // Valid EEPROM signature seen.
  output logic flash_update_start_o           // Autonomous flash update start.
);

  // Register bus state.
  logic aw_got_q;
  logic [31:0] aw_addr_q;
  logic w_got_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // Field state.
  logic addr_width_q;
  logic [3:0] cap_code_q;
  logic [1:0] abc_q;
  logic aupd_en_q;
  logic [1:0] kind_q;
  logic is_flash_q;
  logic sig_valid_q;
  logic strap_s1_q;
  logic strap_s2_q;
  logic [1:0] strap_settle_q;
  logic strap_done_q;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] wr_mask;
  logic [31:0] wr_merged;
  logic [31:0] reg_word;
  logic strap_capture;
  logic load_cfg;
  logic load_sig;
  logic sig_ok;
  logic sw_abc_wr;

  // Full-word decode of the single register; used by both read and write paths.
  function automatic logic reg_hit(input logic [31:0] addr);
    reg_hit = (addr[31:2] == `NVMCF_CTRL_STATUS_OFF >> 2);
  endfunction

  // Handshake outputs are combinational; one write and one read in flight at most.
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // Address and data may arrive in either order; the write acts once both are held.
  assign wr_addr = aw_got_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_got_q ? w_data_q : s_axi_wdata;
  assign wr_strb = w_got_q ? w_strb_q : s_axi_wstrb;
  assign wr_fire = (aw_got_q || aw_take) && (w_got_q || w_take) && !bvalid_q;
  assign wr_hit = wr_fire && reg_hit(wr_addr);
  assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_merged = (reg_word & ~wr_mask) | (wr_data & wr_mask);

  // Reserved ranges are never driven, so they read as zero.
  always_comb begin
    reg_word = 32'h0000_0000;
    reg_word[`NVMCF_ADDR_WIDTH_BIT] = addr_width_q;
    reg_word[`NVMCF_CAP_MSB:`NVMCF_CAP_LSB] = cap_code_q;
    reg_word[`NVMCF_ABC_MSB:`NVMCF_ABC_LSB] = abc_q;
    reg_word[`NVMCF_AUPD_BIT] = aupd_en_q;
    reg_word[`NVMCF_KIND_MSB:`NVMCF_KIND_LSB] = kind_q;
  end

  // Holding registers for an address or data beat that arrives alone.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      aw_got_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_got_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // Write response one cycle after the write acts; unmapped addresses get DECERR.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= `NVMCF_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= reg_hit(wr_addr) ? `NVMCF_RESP_OKAY : `NVMCF_RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data is registered, one cycle after the address is taken.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rvalid_q <= 1'b0;
      rresp_q <= `NVMCF_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= reg_hit(s_axi_araddr) ? `NVMCF_RESP_OKAY : `NVMCF_RESP_DECERR;
      rdata_q <= reg_hit(s_axi_araddr) ? reg_word : 32'h0000_0000;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Software-owned control bits; byte strobes select which lanes land.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      addr_width_q <= `NVMCF_ADDR_WIDTH_RST;
      aupd_en_q <= `NVMCF_AUPD_RST;
    end else if (wr_hit) begin
      addr_width_q <= wr_merged[`NVMCF_ADDR_WIDTH_BIT];
      aupd_en_q <= wr_merged[`NVMCF_AUPD_BIT];
    end
  end

  // The strap pin is asynchronous, so it passes two flip-flops first.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      strap_s1_q <= nvm_kind_strap_pin_i;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Wait for the synchroniser to fill before trusting the strap after reset.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      strap_settle_q <= 2'h0;
      strap_done_q <= 1'b0;
      is_flash_q <= 1'b0;
    end else if (!strap_done_q) begin
      if (strap_settle_q == `NVMCF_STRAP_SETTLE) begin
        strap_done_q <= 1'b1;
        is_flash_q <= strap_s2_q;
      end else begin
        strap_settle_q <= strap_settle_q + 2'h1;
      end
    end
  end

  assign strap_capture = !strap_done_q && (strap_settle_q == `NVMCF_STRAP_SETTLE);
  assign load_cfg = nvm_load_valid_i && (nvm_load_addr_i == `NVMCF_WORD_CFG);
  assign load_sig = nvm_load_valid_i && (nvm_load_addr_i == `NVMCF_WORD_SIG);
  assign sig_ok = nvm_load_data_i[`NVMCF_SIG_MSB:`NVMCF_SIG_LSB] == `NVMCF_SIG_VALID;
  assign sw_abc_wr = wr_hit && strap_done_q && !is_flash_q && !sig_valid_q;

  // Capacity and kind come only from memory word 0Fh; bus writes never touch them.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cap_code_q <= `NVMCF_CAP_RST;
      kind_q <= `NVMCF_KIND_RST;
    end else if (load_cfg) begin
      cap_code_q <= nvm_load_data_i[`NVMCF_CFG_CAP_MSB:`NVMCF_CFG_CAP_LSB];
      kind_q <= nvm_load_data_i[`NVMCF_CFG_KIND_MSB:`NVMCF_CFG_KIND_LSB];
    end
  end

  // Signature state gates whether software may override the address length.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sig_valid_q <= 1'b0;
    end else if (load_sig) begin
      sig_valid_q <= sig_ok;
    end
  end

  // Address-byte count: strap first, then signature, then software for a blank EEPROM.
  // An EEPROM starts provisionally at one byte so it can still be probed.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      abc_q <= `NVMCF_ABC_RSVD;
    end else if (strap_capture) begin
      abc_q <= strap_s2_q ? `NVMCF_ABC_FLASH : `NVMCF_ABC_ONE;
    end else if (load_sig && sig_ok && strap_done_q && !is_flash_q) begin
      abc_q <= nvmcf_addr_bytes(cap_code_q);
    end else if (sw_abc_wr && wr_merged[`NVMCF_ABC_MSB:`NVMCF_ABC_LSB] != `NVMCF_ABC_RSVD) begin
      abc_q <= wr_merged[`NVMCF_ABC_MSB:`NVMCF_ABC_LSB];
    end
  end

  // The flash timer lives in its own module; it is only armed for a flash part.
  nvmcf_aupd_timer u_aupd_timer (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(aupd_en_q && is_flash_q),
    .write_cycle_i(flash_write_cycle_i),
    .update_start_o(flash_update_start_o),
    .timer_busy_o()
  );

  // Field values are also presented as pins for the access engine.
  assign eeprom_addr_width_sel_o = addr_width_q;
  assign eeprom_capacity_code_o = cap_code_q;
  assign nvm_addr_byte_count_o = abc_q;
  assign nvm_kind_o = kind_q;
  assign nvm_is_flash_o = is_flash_q;
  assign nvm_sig_valid_o = sig_valid_q;

  AST_ADDR_WIDTH_WRITE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    wr_hit && wr_strb[1] |=> addr_width_q == $past(wr_data[`NVMCF_ADDR_WIDTH_BIT]))
    else $error("Address width select did not take the written value.");

  AST_CAP_ONLY_FROM_LOAD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !load_cfg |=> $stable(cap_code_q) && $stable(kind_q))
    else $error("Read-only capacity or kind changed without a memory load.");

  AST_CAP_LOADED: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    load_cfg |=> cap_code_q == $past(nvm_load_data_i[`NVMCF_CFG_CAP_MSB:`NVMCF_CFG_CAP_LSB])
      && kind_q == $past(nvm_load_data_i[`NVMCF_CFG_KIND_MSB:`NVMCF_CFG_KIND_LSB]))
    else $error("Capacity or kind not taken from word 0Fh.");

  AST_ABC_NOT_RSVD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    strap_done_q |-> abc_q != `NVMCF_ABC_RSVD)
    else $error("Address-byte count holds the reserved code.");

  AST_STRAP_SETS_ABC: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    strap_capture |=> strap_done_q && abc_q == ($past(strap_s2_q) ? 2'h3 : 2'h1))
    else $error("Strap did not set the address-byte count.");

  AST_SIG_FIXES_ABC: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    load_sig && sig_ok && strap_done_q && !is_flash_q
      |=> abc_q == nvmcf_addr_bytes($past(cap_code_q)) && sig_valid_q)
    else $error("Valid signature did not fix the address length.");

  AST_ABC_LOCKED: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    strap_done_q && (sig_valid_q || is_flash_q) && !load_sig |=> $stable(abc_q))
    else $error("Address-byte count changed after it was fixed.");

  AST_RSVD_ZERO: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rvalid_q |-> rdata_q[19:17] == 3'h0 && rdata_q[22:21] == 2'h0 && rdata_q[31:25] == 7'h00)
    else $error("Reserved bits read as non-zero.");

  AST_READ_ANSWER: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ar_take && reg_hit(s_axi_araddr)
      |=> rvalid_q && rdata_q[`NVMCF_KIND_MSB:`NVMCF_KIND_LSB] == $past(kind_q))
    else $error("Read did not return the memory kind one cycle later.");

  AST_STRAP_HOLDS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    strap_done_q |=> $stable(is_flash_q))
    else $error("Operational memory type changed after the strap was taken.");

  COV_WRITE: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) wr_hit);
  COV_READ: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) ar_take);
  COV_SW_ABC: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) sw_abc_wr);
  COV_SIG: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) load_sig && sig_ok);

endmodule

// [nvmcf_map.svh]
// Constants of the non-volatile memory size, type and configuration fields.
// Assumes inclusion through nvmcf_pkg; holds `define macros only.
//
// What this block does
// - Bit 10 selects EEPROM addressing, 0 for 8 or 9 bit and 1 for 16 bit, reset to 0.
// - Bits 14:11 hold a capacity code, reset 0010b, for 128 B << code; to 0010 one byte.
// - The capacity code is loaded from memory word 0Fh and is read only to software.
// - Bits 16:15 give the address-byte count: 00 reserved, 01 one, 10 two, 11 flash with three.
// - The address-byte count is set after power-on reset from the sampled type strap pin.
// - Software may write the address-byte count only for an EEPROM without valid signature.
// - Bits 19:17, 22:21 and 31:25 read as zero.
// - Bit 20 enables autonomous flash update and resets to 0.
// - With it set on a flash part, write cycles plus expiry of the flash timer start a flash update.
// - Bits 24:23 report the memory kind: EEPROM, stand-alone, shared SPI or super-I/O.
// - The kind field is loaded from word 0Fh for information; the strap sets operation.
// - Capacity and kind reset to fixed constants, 0010b and 00, until memory word 0Fh loads them.
`ifndef NVMCF_MAP_SVH
`define NVMCF_MAP_SVH

`define NVMCF_CTRL_STATUS_OFF 32'h0000_0010
`define NVMCF_ADDR_WIDTH_BIT 10
`define NVMCF_CAP_LSB 11
`define NVMCF_CAP_MSB 14
`define NVMCF_ABC_LSB 15
`define NVMCF_ABC_MSB 16
`define NVMCF_AUPD_BIT 20
`define NVMCF_KIND_LSB 23
`define NVMCF_KIND_MSB 24

`define NVMCF_ADDR_WIDTH_RST 1'h0
`define NVMCF_CAP_RST 4'h2
`define NVMCF_AUPD_RST 1'h0
`define NVMCF_KIND_RST 2'h0
`define NVMCF_ABC_RSVD 2'h0
`define NVMCF_ABC_ONE 2'h1
`define NVMCF_ABC_TWO 2'h2
`define NVMCF_ABC_FLASH 2'h3
`define NVMCF_CAP_ONE_BYTE_MAX 4'h2

`define NVMCF_WORD_CFG 8'h0F
`define NVMCF_WORD_SIG 8'h12
`define NVMCF_CFG_CAP_LSB 8
`define NVMCF_CFG_CAP_MSB 11
`define NVMCF_CFG_KIND_LSB 12
`define NVMCF_CFG_KIND_MSB 13
`define NVMCF_SIG_LSB 14
`define NVMCF_SIG_MSB 15
`define NVMCF_SIG_VALID 2'h1

`define NVMCF_STRAP_SETTLE 2'h2
`define NVMCF_CLK_PERIOD_NS 5
`define NVMCF_FLASH_TIMER_NS 10000
// The flash timer length must be a whole number of clock periods.
`define NVMCF_FLASH_TIMER_CYC (`NVMCF_FLASH_TIMER_NS / `NVMCF_CLK_PERIOD_NS)

`define NVMCF_RESP_OKAY 2'h0
`define NVMCF_RESP_DECERR 2'h3

`endif

// [nvmcf_pkg.sv]
// Types and shared helpers of the non-volatile memory configuration block.
// Assumes nvmcf_map.svh is on the include path.
`include "nvmcf_map.svh"

package nvmcf_pkg;

  // One-hot states of the autonomous flash update sequencer.
  typedef enum logic [2:0] {
    AUPD_IDLE  = 3'b001,
    AUPD_ARMED = 3'b010,
    AUPD_FIRE  = 3'b100
  } nvmcf_aupd_state_t;

  // Address bytes implied by a capacity code; small parts need only one byte.
  function automatic logic [1:0] nvmcf_addr_bytes(input logic [3:0] code);
    nvmcf_addr_bytes = (code <= `NVMCF_CAP_ONE_BYTE_MAX) ? `NVMCF_ABC_ONE : `NVMCF_ABC_TWO;
  endfunction

endpackage

// [nvmcf_aupd_timer.sv]
// Flash timer that starts an autonomous flash update after write activity.
// Assumes write pulses from logic on the same clock; no synchroniser needed.
`timescale 1ns/1ps
`include "nvmcf_map.svh"

module nvmcf_aupd_timer
  import nvmcf_pkg::*;
(
  input wire logic core_clk_i,     // Core clock.
  input wire logic sys_rst_i,      // Synchronous reset, active high.
  input wire logic enable_i,       // Autonomous update enable.
  input wire logic write_cycle_i,  // One-cycle pulse per flash write cycle.
  output logic update_start_o,     // One-cycle pulse that starts the update.
  output logic timer_busy_o        // Timer running after writes.
);

  localparam logic [11:0] TimerLast = 12'(`NVMCF_FLASH_TIMER_CYC - 1);

  nvmcf_aupd_state_t state_q;
  logic [11:0] cnt_q;

  // Each write restarts the timer, so the update waits for a quiet period.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_q <= AUPD_IDLE;
      cnt_q <= 12'h000;
    end else begin
      case (state_q)
        AUPD_IDLE: begin
          if (enable_i && write_cycle_i) begin
            state_q <= AUPD_ARMED;
            cnt_q <= TimerLast;
          end
        end
        AUPD_ARMED: begin
          if (!enable_i) begin
            state_q <= AUPD_IDLE;
          end else if (write_cycle_i) begin
            cnt_q <= TimerLast;
          end else if (cnt_q == 12'h000) begin
            state_q <= AUPD_FIRE;
          end else begin
            cnt_q <= cnt_q - 12'h001;
          end
        end
        AUPD_FIRE: begin
          state_q <= AUPD_IDLE;
        end
        default: begin
          state_q <= AUPD_IDLE;
        end
      endcase
    end
  end

  // Outputs come straight from the state flip-flops.
  assign update_start_o = (state_q == AUPD_FIRE);
  assign timer_busy_o = (state_q == AUPD_ARMED);

  AST_FIRE_AFTER_EXPIRY: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    update_start_o |-> $past(state_q) == AUPD_ARMED && $past(cnt_q) == 12'h000
      && $past(enable_i) && !$past(write_cycle_i))
    else $error("Flash update started without timer expiry.");

  AST_NO_FIRE_DISABLED: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !enable_i && !timer_busy_o |=> !update_start_o)
    else $error("Flash update started while autonomous update disabled.");

  COV_FIRE: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) update_start_o);

endmodule

// [nvmcf_nvm_model.sv]
// Behavioural model of the memory part behind the configuration fields.
// Assumes the bench calls send_word on the design's clock.
`timescale 1ns/1ps

module nvmcf_nvm_model (
  input wire logic core_clk_i,        // Core clock.
  input wire logic flash_sel_i,       // High when a flash part is fitted.
  output logic nvm_kind_strap_pin_o,  // Type strap level.
  output logic nvm_load_valid_o,      // Word valid pulse.
  output logic [7:0] nvm_load_addr_o, // Word address.
  output logic [15:0] nvm_load_data_o // Word data.
);
  // The strap is a board level, so it follows the fitted part.
  assign nvm_kind_strap_pin_o = flash_sel_i;

  // Nothing is offered before the first word.
  initial begin
    nvm_load_valid_o = 1'h0;
    nvm_load_addr_o = 8'h00;
    nvm_load_data_o = 16'h0000;
  end

  // Offer one stored word for a cycle, then invert the lines so stale data never matches.
  task automatic send_word(input logic [7:0] addr, input logic [15:0] data);
    @(posedge core_clk_i);
    nvm_load_valid_o <= 1'h1;
    nvm_load_addr_o <= addr;
    nvm_load_data_o <= data;
    @(posedge core_clk_i);
    nvm_load_valid_o <= 1'h0;
    nvm_load_addr_o <= ~addr;
    nvm_load_data_o <= ~data;
  endtask
endmodule

// [tb_top.sv]
// Testbench of the memory size, type and configuration fields.
// Assumes the package, the design and the memory model are compiled first.
`timescale 1ns/1ps

module tb_top;
  import nvmcf_pkg::*;
  logic core_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, flash_write_cycle_i = 1'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, nvm_addr_byte_count_o, nvm_kind_o, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic nvm_kind_strap_pin_i, nvm_load_valid_i, flash_sel = 1'h0;
  logic [7:0] nvm_load_addr_i;
  logic [15:0] nvm_load_data_i;
  logic eeprom_addr_width_sel_o, nvm_is_flash_o, nvm_sig_valid_o, flash_update_start_o;
  logic [3:0] eeprom_capacity_code_o;
  int num_errors = 0, checked = 0, starts = 0, n;

  // Free running 200 MHz clock.
  always #2.5 core_clk_i = ~core_clk_i;

  nvmcf_nvm_cfg u_nvmcf_nvm_cfg (.core_clk_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nvm_kind_strap_pin_i, .nvm_load_valid_i,
    .nvm_load_addr_i, .nvm_load_data_i, .flash_write_cycle_i, .eeprom_addr_width_sel_o,
    .eeprom_capacity_code_o, .nvm_addr_byte_count_o, .nvm_kind_o, .nvm_is_flash_o,
    .nvm_sig_valid_o, .flash_update_start_o);

  nvmcf_nvm_model u_nvmcf_nvm_model (.core_clk_i, .flash_sel_i(flash_sel),
    .nvm_kind_strap_pin_o(nvm_kind_strap_pin_i), .nvm_load_valid_o(nvm_load_valid_i),
    .nvm_load_addr_o(nvm_load_addr_i), .nvm_load_data_o(nvm_load_data_i));

  // Count update starts so a missing or extra start shows up later.
  always @(posedge core_clk_i) begin
    if (flash_update_start_o === 1'h1) begin
      starts++;
    end
  end

  // Compare one value and report a difference at once.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Expected register image; the low bits belong to other logic and are masked.
  function automatic logic [31:0] fv(input logic aw, input logic [3:0] cap,
      input logic [1:0] abc, input logic au, input logic [1:0] kd);
    return {7'h00, kd, 2'h0, au, 3'h0, abc, cap, aw, 10'h000};
  endfunction

  // One write; address and data are released each at its own acceptance edge.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk_i);
      if (!aw_ok && s_axi_awready === 1'h1) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_ok && s_axi_wready === 1'h1) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge core_clk_i); while (s_axi_bvalid !== 1'h1);
    chk("bresp", s_axi_bresp, er);
    s_axi_bready <= 1'h0;
  endtask

  // One read; data and response are taken at the edge that sees rvalid.
  task automatic axi_rd(input logic [31:0] a);
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge core_clk_i); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge core_clk_i); while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Read the register and compare the fields of this block.
  task automatic rchk(input logic [31:0] exp);
    axi_rd(32'h0000_0010);
    chk("rresp", rsp, 2'h0);
    chk("reg", rd & 32'hffff_fc00, exp);
  endtask

  // Reset with the given strap; outputs are checked inside reset and after capture.
  task automatic rst(input logic strap);
    @(posedge core_clk_i);
    sys_rst_i <= 1'h1;
    flash_sel <= strap;
    repeat (2) @(posedge core_clk_i);
    chk("rst_out", {eeprom_addr_width_sel_o, eeprom_capacity_code_o, nvm_addr_byte_count_o,
      nvm_kind_o, nvm_is_flash_o, nvm_sig_valid_o, flash_update_start_o}, 32'h100);
    sys_rst_i <= 1'h0;
    repeat (6) @(posedge core_clk_i);
    chk("abc", nvm_addr_byte_count_o, strap ? 2'h3 : 2'h1);
    chk("is_flash", nvm_is_flash_o, strap);
  endtask

  // Pulse one write cycle, then wait for an update start up to a limit.
  task automatic upd(input int lim, output int cyc);
    @(posedge core_clk_i);
    flash_write_cycle_i <= 1'h1;
    @(posedge core_clk_i);
    flash_write_cycle_i <= 1'h0;
    cyc = 1;
    while (flash_update_start_o !== 1'h1 && cyc < lim) begin
      @(posedge core_clk_i);
      cyc++;
    end
  endtask

  // Hand over one memory word and let it land.
  task automatic word(input logic [7:0] a, input logic [15:0] d);
    u_nvmcf_nvm_model.send_word(a, d);
    repeat (2) @(posedge core_clk_i);
  endtask

  // Print the counts and the verdict, then stop.
  task automatic end_of_test;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence: EEPROM strap first, then flash strap with the update timer.
  initial begin
    rst(1'h0);
    rchk(fv(1'h0, 4'h2, 2'h1, 1'h0, 2'h0));
    wr(32'h0000_0010, 32'hffff_ffff, 2'h0);
    rchk(fv(1'h1, 4'h2, 2'h3, 1'h1, 2'h0));
    wr(32'h0000_0010, 32'h0010_0400, 2'h0);
    rchk(fv(1'h1, 4'h2, 2'h3, 1'h1, 2'h0));
    wr(32'h0000_0010, 32'h0011_0400, 2'h0);
    rchk(fv(1'h1, 4'h2, 2'h2, 1'h1, 2'h0));
    for (int k = 0; k < 4; k++) begin
      word(8'h0f, {2'h0, k[1:0], 12'h500});
      chk("kind", nvm_kind_o, k[1:0]);
      chk("cap", eeprom_capacity_code_o, 4'h5);
    end
    wr(32'h0000_0010, 32'hffff_ffff, 2'h0);
    rchk(fv(1'h1, 4'h5, 2'h3, 1'h1, 2'h3));
    word(8'h12, 16'h4000);
    chk("sig", nvm_sig_valid_o, 1'h1);
    chk("abc", nvm_addr_byte_count_o, 2'h2);
    wr(32'h0000_0010, 32'h0010_8400, 2'h0);
    rchk(fv(1'h1, 4'h5, 2'h2, 1'h1, 2'h3));
    word(8'h0f, 16'h0200);
    word(8'h12, 16'h4000);
    chk("abc", nvm_addr_byte_count_o, 2'h1);
    word(8'h12, 16'h8000);
    chk("sig", nvm_sig_valid_o, 1'h0);
    wr(32'h0000_0010, 32'h0011_0400, 2'h0);
    rchk(fv(1'h1, 4'h2, 2'h2, 1'h1, 2'h0));
    axi_rd(32'h0000_0014);
    chk("rresp", rsp, 2'h3);
    chk("rdata", rd, 32'h0);
    wr(32'h0000_0014, 32'hffff_ffff, 2'h3);
    rchk(fv(1'h1, 4'h2, 2'h2, 1'h1, 2'h0));
    // Only lane 1 lands: bit 10 clears, bit 20 in lane 2 must keep its value.
    s_axi_wstrb <= 4'h2;
    wr(32'h0000_0010, 32'h0000_0000, 2'h0);
    rchk(fv(1'h0, 4'h2, 2'h2, 1'h1, 2'h0));
    s_axi_wstrb <= 4'hf;
    rst(1'h1);
    rchk(fv(1'h0, 4'h2, 2'h3, 1'h0, 2'h0));
    word(8'h12, 16'h4000);
    wr(32'h0000_0010, 32'h0000_8000, 2'h0);
    chk("abc", nvm_addr_byte_count_o, 2'h3);
    upd(2200, n);
    chk("no_upd", starts, 0);
    wr(32'h0000_0010, 32'h0010_0000, 2'h0);
    upd(1000, n);
    upd(2200, n);
    chk("gap", n inside {[1995:2010]}, 1'h1);
    @(posedge core_clk_i);
    chk("pulse", flash_update_start_o, 1'h0);
    chk("starts", starts, 1);
    upd(100, n);
    wr(32'h0000_0010, 32'h0000_0000, 2'h0);
    repeat (2200) @(posedge core_clk_i);
    chk("starts", starts, 1);
    end_of_test;
  end

  // Cut a hang short; the tests need well under half of this span.
  initial begin
    #100000;
    num_errors++;
    end_of_test;
  end
endmodule
